/* logic/ccp_unit.sv */
// Purpose: compare mode and standard pulse-width mode of one capture/compare/PWM unit
// Assumes: wide and narrow timers live outside; their counts and increment strobes arrive here
// Notes: register port is byte wide, read data stand one cycle after the read strobe
//
// Overview of operation
// - compare 16-bit value with wide timer each update
// - one match action chosen by mode field
// - interrupt flag set together with match action
// - zero control write forces compare latch low
// - mode 1010 flags only, pin released
// - mode 1011 resets timer, starts conversion, pin released
// - trigger at match, timer clear next edge
// - trigger reset never sets timer overflow flag
// - match lost before clear edge skips reset
// - compare not required during sleep
// - pulse-width waveform with ten-bit resolution
// - period, duty from period, duty, control only
// - zero control write releases pin in pulse mode
// - duty is compare low then fraction bits
// - period match clears timer, sets pin unless duty is zero, buffers duty
// - ten-bit time base equal buffered duty clears pin
`timescale 1ns/1ps
`include "ccp_unit_params.svh"
`default_nettype none

module ccp_unit (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire ccp_unit_pkg::reg_req_t i_bus,
	output logic [7:0] o_rdata,
	input wire logic [15:0] i_wide_timer,
	input wire logic i_wide_tick,
	input wire logic i_adc_enable,
	input wire logic i_sleep,
	input wire logic [7:0] i_narrow_timer,
	input wire logic [7:0] i_narrow_period,
	input wire logic i_narrow_tick,
	input wire logic [1:0] i_narrow_fine,
	output logic o_unit_pin,
	output logic o_unit_pin_oe_n,
	output logic o_special_event,
	output logic o_adc_start,
	output logic o_wide_timer_clear,
	output logic o_unit_interrupt_flag
);
	import ccp_unit_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// state and decoded views of it
	state_t r;
	state_t next_r;
	mode_t mode;
	logic pwm_mode;
	logic drives_pin;
	logic [15:0] compare_value;
	logic wide_match;
	logic period_match;
	logic duty_match;
	logic [9:0] duty_value;
	logic [9:0] time_base;
	logic wr_control;
	logic wr_cmp_low;
	logic wr_cmp_high;
	logic wr_status;

	// codes outside the enum read back as they are; codes D to F run pulse mode, the rest only set the flag on a match
	assign mode = mode_t'(r.control[`MODE_FIELD_MSB:`MODE_FIELD_LSB]);
	assign pwm_mode = (r.control[3:2] == 2'h3);
	assign compare_value = {r.cmp_high, r.cmp_low};
	assign duty_value = {r.cmp_low, r.control[`DUTY_FRACTION_MSB:`DUTY_FRACTION_LSB]};
	assign time_base = {i_narrow_timer, i_narrow_fine};

	// a match counts only on a timer update; with the oscillator stopped only the pulse-mode compares still run
	assign wide_match = i_wide_tick && !i_sleep && !pwm_mode && (compare_value == i_wide_timer);

	// timer value is the pre-increment count while the strobe is high
	assign period_match = pwm_mode && i_narrow_tick && (i_narrow_timer == i_narrow_period);
	assign duty_match = pwm_mode && (time_base == {r.cmp_high, r.duty_latch});

	// register port decode
	assign wr_control = i_bus.wr && (i_bus.addr == `OFS_UNIT_CONTROL);
	assign wr_cmp_low = i_bus.wr && (i_bus.addr == `OFS_COMPARE_VALUE_LOW);
	assign wr_cmp_high = i_bus.wr && (i_bus.addr == `OFS_COMPARE_VALUE_HIGH);
	assign wr_status = i_bus.wr && (i_bus.addr == `OFS_UNIT_STATUS);

	////////////////////////////////////////////////////////////////////////////
	// pin ownership: only the pin actions and pulse mode take the pin
	always_comb begin
		unique case (mode)
			MODE_TOGGLE, MODE_SET_HIGH, MODE_SET_LOW: drives_pin = 1'b1;
			MODE_SOFT_INT: drives_pin = 1'b0;
			MODE_SPECIAL: drives_pin = 1'b0;
			default: drives_pin = pwm_mode;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_r = r;
		next_r.sev_pulse = 1'b0;
		next_r.adc_pulse = 1'b0;
		next_r.rdata = `RST_READ_DATA;

		// clearing the clear request: either the timer took it on its edge,
		// or software moved the compare value away first and the reset is skipped
		if (r.sev_pending && (i_wide_tick || (compare_value != i_wide_timer))) begin
			next_r.sev_pending = 1'b0;
		end

		// flag cleared by writing one; a match in the same cycle wins below
		if (wr_status && i_bus.wdata[`STATUS_FLAG_BIT]) begin
			next_r.flag = 1'b0;
		end

		// compare match: one action, flag in the same cycle
		if (wide_match) begin
			next_r.flag = 1'b1;
			unique case (mode)
				MODE_TOGGLE: next_r.pin_latch = !r.pin_latch;
				MODE_SET_HIGH: next_r.pin_latch = 1'b1;
				MODE_SET_LOW: next_r.pin_latch = 1'b0;
				MODE_SPECIAL: begin
					next_r.sev_pulse = 1'b1;
					next_r.adc_pulse = i_adc_enable;
					next_r.sev_pending = 1'b1;
				end
				default: next_r.pin_latch = r.pin_latch;
			endcase
		end

		// pulse mode: period end wins over duty end in the same cycle
		if (period_match) begin
			next_r.cmp_high = r.cmp_low;
			next_r.duty_latch = r.control[`DUTY_FRACTION_MSB:`DUTY_FRACTION_LSB];
			next_r.pin_latch = (duty_value != 10'h000);
		end else if (duty_match) begin
			next_r.pin_latch = 1'b0;
		end

		// software writes; compare high is the duty buffer and read-only in pulse mode
		if (wr_control) begin
			next_r.control = i_bus.wdata;
			if (i_bus.wdata == `RST_UNIT_CONTROL) begin
				next_r.pin_latch = 1'b0;
			end
		end
		if (wr_cmp_low) begin
			next_r.cmp_low = i_bus.wdata;
		end
		if (wr_cmp_high && !pwm_mode) begin
			next_r.cmp_high = i_bus.wdata;
		end

		// read data for the cycle after the strobe only
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				`OFS_UNIT_CONTROL: next_r.rdata = r.control;
				`OFS_COMPARE_VALUE_LOW: next_r.rdata = r.cmp_low;
				`OFS_COMPARE_VALUE_HIGH: next_r.rdata = r.cmp_high;
				`OFS_UNIT_STATUS: next_r.rdata = {7'h00, r.flag};
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			r.control <= `RST_UNIT_CONTROL;
			r.cmp_low <= `RST_COMPARE_VALUE;
			r.cmp_high <= `RST_COMPARE_VALUE;
			r.duty_latch <= 2'h0;
			r.pin_latch <= 1'b0;
			r.flag <= 1'b0;
			r.sev_pending <= 1'b0;
			r.sev_pulse <= 1'b0;
			r.adc_pulse <= 1'b0;
			r.rdata <= `RST_READ_DATA;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs; the clear request is a level the wide timer applies at its next
	// increment edge in place of counting, and it never reports that as an overflow
	assign o_rdata = r.rdata;
	assign o_unit_pin = r.pin_latch;
	assign o_unit_pin_oe_n = !drives_pin;
	assign o_special_event = r.sev_pulse;
	assign o_adc_start = r.adc_pulse;
	assign o_wide_timer_clear = r.sev_pending;
	assign o_unit_interrupt_flag = r.flag;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_reset_n);

	sequence s_special_match;
		wide_match && (mode == MODE_SPECIAL);
	endsequence

	sequence s_trigger_out;
		o_special_event && o_wide_timer_clear;
	endsequence

	sequence s_period_end;
		period_match && !wr_control;
	endsequence

	chk_match_flag: assert property (wide_match |=> o_unit_interrupt_flag)
		else $error("match did not set the interrupt flag");

	chk_toggle_pin: assert property ((wide_match && mode == MODE_TOGGLE && !wr_control)
		|=> (o_unit_pin != $past(o_unit_pin)))
		else $error("toggle match did not invert the pin");

	chk_set_pin: assert property ((wide_match && mode == MODE_SET_HIGH && !wr_control)
		|=> o_unit_pin && o_unit_interrupt_flag)
		else $error("set match did not drive the pin high");

	chk_zero_write: assert property ((wr_control && i_bus.wdata == 8'h00)
		|=> !o_unit_pin && o_unit_pin_oe_n)
		else $error("zero control write left the pin latch or drive");

	chk_soft_release: assert property ((mode == MODE_SOFT_INT) |-> o_unit_pin_oe_n)
		else $error("software interrupt mode drives the pin");

	chk_special_trigger: assert property (s_special_match |=> s_trigger_out ##0 o_unit_pin_oe_n)
		else $error("special match missed trigger or drove the pin");

	chk_clear_wait: assert property ((s_special_match ##1 (!i_wide_tick && compare_value == i_wide_timer))
		|=> o_wide_timer_clear)
		else $error("timer clear request dropped before the timer edge");

	chk_skip_reset: assert property ((o_wide_timer_clear && !i_wide_tick && compare_value != i_wide_timer)
		|=> !o_wide_timer_clear)
		else $error("timer clear kept after match was removed");

	chk_adc_start: assert property (s_special_match |=> (o_adc_start == $past(i_adc_enable)))
		else $error("conversion start does not follow converter enable");

	chk_sleep_quiet: assert property (i_sleep |=> !o_special_event)
		else $error("trigger raised while asleep");

	chk_period_reload: assert property (s_period_end
		|=> (r.cmp_high == $past(r.cmp_low)) && (o_unit_pin == ($past(duty_value) != 10'h000)))
		else $error("period end did not buffer duty or set the pin");

	chk_duty_clear: assert property ((duty_match && !period_match && !wr_control) |=> !o_unit_pin)
		else $error("duty match did not clear the pin");

	chk_pwm_drive: assert property (pwm_mode |-> !o_unit_pin_oe_n)
		else $error("pulse mode does not drive the pin");

	chk_read_once: assert property (!i_bus.rd |=> (o_rdata == 8'h00))
		else $error("read data stood beyond its cycle");

	////////////////////////////////////////////////////////////////////////////
	// flag and timer-clear bookkeeping; a set and a clear in one cycle
	// must resolve to the set, or software would lose a match
	sequence s_flag_clear_req;
		wr_status && i_bus.wdata[`STATUS_FLAG_BIT];
	endsequence

	sequence s_timer_edge;
		o_wide_timer_clear && i_wide_tick;
	endsequence

	chk_set_low: assert property ((wide_match && mode == MODE_SET_LOW && !wr_control)
		|=> !o_unit_pin && o_unit_interrupt_flag)
		else $error("clear match did not drive the pin low");

	chk_soft_keep: assert property ((wide_match && mode == MODE_SOFT_INT && !wr_control)
		|=> (o_unit_pin == $past(o_unit_pin)) && o_unit_interrupt_flag)
		else $error("software interrupt match moved the pin latch");

	chk_special_release: assert property ((mode == MODE_SPECIAL) |-> o_unit_pin_oe_n)
		else $error("trigger mode drives the pin");

	chk_adc_with_event: assert property (o_adc_start |-> o_special_event)
		else $error("conversion start without a trigger");

	// the trigger must come from a match, never from a stale request
	chk_trigger_cause: assert property (o_special_event
		|-> $past(wide_match && mode == MODE_SPECIAL))
		else $error("trigger raised without a special match");

	chk_clear_start: assert property (s_special_match |=> o_wide_timer_clear)
		else $error("special match did not request a timer clear");

	// a fresh match on the clearing edge may re-arm the request
	chk_clear_drop: assert property ((s_timer_edge ##0 !wide_match) |=> !o_wide_timer_clear)
		else $error("timer clear request outlived the timer edge");

	chk_flag_hold: assert property ((o_unit_interrupt_flag && !wr_status) |=> o_unit_interrupt_flag)
		else $error("interrupt flag dropped without a clear");

	chk_flag_clear: assert property ((s_flag_clear_req ##0 !wide_match) |=> !o_unit_interrupt_flag)
		else $error("status write did not clear the flag");

	chk_flag_wins: assert property ((s_flag_clear_req ##0 wide_match) |=> o_unit_interrupt_flag)
		else $error("clear beat a match in the same cycle");

	chk_sleep_flag: assert property ((i_sleep && !o_unit_interrupt_flag) |=> !o_unit_interrupt_flag)
		else $error("flag raised while asleep");

	////////////////////////////////////////////////////////////////////////////
	// pulse mode buffer and register port; the duty buffer may only move
	// at a period end, otherwise the waveform would glitch mid-period
	chk_duty_hold: assert property ((pwm_mode && !period_match)
		|=> (r.cmp_high == $past(r.cmp_high)))
		else $error("duty buffer moved outside a period end");

	chk_zero_duty: assert property ((s_period_end ##0 duty_value == 10'h000)
		|=> !o_unit_pin)
		else $error("zero duty still set the pin");

	chk_off_release: assert property ((mode == MODE_OFF) |-> o_unit_pin_oe_n)
		else $error("unit off but pin still driven");

	chk_control_write: assert property (wr_control
		|=> (r.control == $past(i_bus.wdata)))
		else $error("control write did not land");

	chk_read_control: assert property ((i_bus.rd && i_bus.addr == `OFS_UNIT_CONTROL)
		|=> (o_rdata == $past(r.control)))
		else $error("control read returned the wrong byte");

endmodule
`default_nettype wire

/* logic/ccp_unit_params.svh */
// Purpose: register offsets, field positions and reset values of the compare/PWM unit
// Assumes: byte-wide register port with a 2-bit register index
// Notes: definitions only, no logic
`ifndef CCP_UNIT_PARAMS_SVH
`define CCP_UNIT_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// register indices on the plain register port
`define OFS_UNIT_CONTROL 2'h0
`define OFS_COMPARE_VALUE_LOW 2'h1
`define OFS_COMPARE_VALUE_HIGH 2'h2
`define OFS_UNIT_STATUS 2'h3

////////////////////////////////////////////////////////////////////////////////
// field positions inside unit_control and the status register
`define MODE_FIELD_LSB 0
`define MODE_FIELD_MSB 3
`define DUTY_FRACTION_LSB 4
`define DUTY_FRACTION_MSB 5
`define STATUS_FLAG_BIT 0

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RST_UNIT_CONTROL 8'h00
`define RST_COMPARE_VALUE 8'h00
`define RST_READ_DATA 8'h00

`endif

/* logic/ccp_unit_pkg.sv */
// Purpose: types shared by the compare/PWM unit and its bench
// Assumes: nothing beyond the params header
// Notes: mode codes are the 4-bit unit_mode_field encodings
`default_nettype none
package ccp_unit_pkg;

	// match actions and pulse-width mode selected by unit_mode_field
	typedef enum logic [3:0] {
		MODE_OFF = 4'h0,
		MODE_TOGGLE = 4'h2,
		MODE_SET_HIGH = 4'h8,
		MODE_SET_LOW = 4'h9,
		MODE_SOFT_INT = 4'hA,
		MODE_SPECIAL = 4'hB,
		MODE_PWM = 4'hC
	} mode_t;

	// one register port request
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// whole state of the unit
	typedef struct packed {
		logic [7:0] control;
		logic [7:0] cmp_low;
		logic [7:0] cmp_high;
		logic [1:0] duty_latch;
		logic pin_latch;
		logic flag;
		logic sev_pending;
		logic sev_pulse;
		logic adc_pulse;
		logic [7:0] rdata;
	} state_t;

endpackage
`default_nettype wire

/* testbench/ccp_unit_tb_top.sv */
// Purpose: self-checking bench for the compare and pulse-width unit
// Assumes: timers come from timer_partner
// Notes: pulse width reads one cycle long from registered clear
`timescale 1ns/1ps
`include "ccp_unit_params.svh"
`default_nettype none
module ccp_unit_tb_top;
	import ccp_unit_pkg::*;
	logic clk, rst_n, adc_en, sleep_req, wtick, ovf, ntick, pin, oe_n, sev, adc, wclr, flag;
	logic [7:0] rdata, period, ntmr, conv;
	logic [1:0] fine;
	logic [15:0] wide;
	reg_req_t bus;
	int err_total, check_count, n;
	logic [7:0] mode_tab [7] = '{8'h02, 8'h02, 8'h08, 8'h09, 8'h02, 8'h0A, 8'h0B};
	logic [1:0] pin_tab [7] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2};
	logic [7:0] pwm_tab [3][3] = '{'{8'h01, 8'h2C, 8'h0E}, '{8'h01, 8'h0C, 8'h0A}, '{8'h00, 8'h0C, 8'h00}};

	ccp_unit u_dut (.i_mclk(clk), .i_reset_n(rst_n), .i_bus(bus), .o_rdata(rdata),
		.i_wide_timer(wide), .i_wide_tick(wtick), .i_adc_enable(adc_en), .i_sleep(sleep_req),
		.i_narrow_timer(ntmr), .i_narrow_period(period), .i_narrow_tick(ntick), .i_narrow_fine(fine),
		.o_unit_pin(pin), .o_unit_pin_oe_n(oe_n), .o_special_event(sev), .o_adc_start(adc),
		.o_wide_timer_clear(wclr), .o_unit_interrupt_flag(flag));
	timer_partner u_partner (.i_mclk(clk), .i_reset_n(rst_n), .i_wide_clear(wclr), .i_adc_start(adc),
		.i_period(period), .o_wide_timer(wide), .o_wide_tick(wtick), .o_overflow(ovf),
		.o_narrow_timer(ntmr), .o_narrow_tick(ntick), .o_narrow_fine(fine), .o_conv_count(conv));

	////////////////////////////////////////////////////////////////////////////////
	// shared compare, bus and closing tasks
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 check_val(rdata, exp);
		@(posedge clk);
	endtask
	// target eight timer steps ahead so both byte writes land first
	task automatic arm(input logic [7:0] mode);
		logic [15:0] tgt;
		wr(`OFS_UNIT_CONTROL, mode);
		wr(`OFS_UNIT_STATUS, 8'h01);
		tgt = wide + 16'h0008;
		wr(`OFS_COMPARE_VALUE_HIGH, tgt[15:8]);
		wr(`OFS_COMPARE_VALUE_LOW, tgt[7:0]);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// free-running clock and hang guard
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (8000) @(posedge clk);
		err_total++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_n = 1'b0;
		bus = '0;
		adc_en = 1'b1;
		sleep_req = 1'b0;
		period = 8'h03;
		err_total = 0;
		check_count = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check_val({oe_n, pin}, 16'h0002);
		for (int a = 0; a < 4; a++) rd_chk(a[1:0], 8'h00);
		wr(`OFS_COMPARE_VALUE_LOW, 8'hA5);
		rd_chk(`OFS_COMPARE_VALUE_LOW, 8'hA5);
		$display("test registers done");
		// every match action; flag and action seen in the same cycle
		for (int i = 0; i < 7; i++) begin
			arm(mode_tab[i]);
			n = 0;
			do begin
				@(posedge clk);
				#1 n++;
			end while (flag !== 1'b1 && n < 200);
			check_val(flag, 16'h0001);
			check_val({oe_n, pin & ~oe_n}, pin_tab[i]);
			check_val({sev, adc}, (mode_tab[i] == 8'h0B) ? 16'h0003 : 16'h0000);
			if (mode_tab[i] == 8'h0B) begin
				repeat (3) @(posedge clk);
				#1 check_val(wide, 16'h0000);
				check_val({ovf, conv}, 16'h0001);
			end
			@(posedge clk);
		end
		$display("test compare actions done");
		wr(`OFS_UNIT_CONTROL, 8'h00);
		#1 check_val({oe_n, pin}, 16'h0002);
		@(posedge clk);
		// stopped oscillator: a due match must not be taken
		sleep_req <= 1'b1;
		arm(8'h08);
		repeat (60) @(posedge clk);
		check_val(flag, 16'h0000);
		sleep_req <= 1'b0;
		$display("test sleep done");
		// duty table: high cycles over two 16-cycle periods
		for (int i = 0; i < 3; i++) begin
			wr(`OFS_UNIT_CONTROL, pwm_tab[i][1]);
			wr(`OFS_COMPARE_VALUE_LOW, pwm_tab[i][0]);
			repeat (40) @(posedge clk);
			n = 0;
			repeat (32) begin
				@(posedge clk);
				#1 n += (pin === 1'b1);
			end
			check_val(16'(n), pwm_tab[i][2]);
			check_val(oe_n, 16'h0000);
			@(posedge clk);
		end
		wr(`OFS_COMPARE_VALUE_HIGH, 8'h55);
		rd_chk(`OFS_COMPARE_VALUE_HIGH, 8'h00);
		wr(`OFS_UNIT_CONTROL, 8'h00);
		#1 check_val({oe_n, pin}, 16'h0002);
		$display("test pulse width done");
		end_sim();
	end
endmodule
`default_nettype wire

/* testbench/timer_partner.sv */
// Purpose: wide and narrow timers plus converter beside the unit
// Assumes: both timers step on every fourth clock
// Notes: behavioural, no bus of its own
`timescale 1ns/1ps
`default_nettype none
module timer_partner (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_wide_clear,
	input wire logic i_adc_start,
	input wire logic [7:0] i_period,
	output logic [15:0] o_wide_timer,
	output logic o_wide_tick,
	output logic o_overflow,
	output logic [7:0] o_narrow_timer,
	output logic o_narrow_tick,
	output logic [1:0] o_narrow_fine,
	output logic [7:0] o_conv_count
);
	logic [1:0] phase;
	// prescale phase doubles as the two low time-base bits
	assign o_narrow_fine = phase;
	assign o_narrow_tick = (phase == 2'h3);
	////////////////////////////////////////////////////////////////////////////////
	// synchronous timers on the instruction clock, never the raw oscillator
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			phase <= 2'h0;
			o_wide_timer <= 16'h0000;
			o_wide_tick <= 1'b0;
			o_overflow <= 1'b0;
			o_narrow_timer <= 8'h00;
			o_conv_count <= 8'h00;
		end else begin
			phase <= phase + 2'h1;
			o_wide_tick <= o_narrow_tick;
			if (o_narrow_tick) begin
				// a pending clear replaces the step and never flags overflow
				o_wide_timer <= i_wide_clear ? 16'h0000 : o_wide_timer + 16'h0001;
				if (!i_wide_clear && o_wide_timer == 16'hFFFF) o_overflow <= 1'b1;
				o_narrow_timer <= (o_narrow_timer == i_period) ? 8'h00 : o_narrow_timer + 8'h01;
			end
			if (i_adc_start) o_conv_count <= o_conv_count + 8'h01;
		end
	end
endmodule
`default_nettype wire
